// ==== hw/epevs_pkg.sv ====
// Package for the endpoint event status block: offsets, bit fields, reset values
package epevs_pkg;
   // Register indices; the bus byte address is four times the index
   localparam logic [7:0] EPEVS_OFF_EP4       = 8'hb9;
   localparam logic [7:0] EPEVS_OFF_EP5       = 8'hba;
   localparam logic [7:0] EPEVS_OFF_ALARM_HI  = 8'hbc;
   localparam logic [7:0] EPEVS_OFF_ALARM_LO  = 8'hbd;
   localparam logic [7:0] EPEVS_OFF_GRP_EN    = 8'hc4;
   localparam logic [7:0] EPEVS_OFF_SUMMARY   = 8'hc8;
   // Event status bit positions
   localparam int EPEVS_BIT_OUT_ERR   = 0;
   localparam int EPEVS_BIT_IN_ERR    = 1;
   localparam int EPEVS_BIT_OUT_NAK   = 2;
   localparam int EPEVS_BIT_IN_NAK    = 3;
   localparam int EPEVS_BIT_OUT_ACK   = 4;
   localparam int EPEVS_BIT_IN_ACK    = 5;
   localparam int EPEVS_BIT_OUT_SHORT = 6;
   // Group enable bit positions
   localparam int EPEVS_EN_EP4        = 3;
   localparam int EPEVS_EN_EP5        = 4;
   localparam int EPEVS_EN_ALARM_IN   = 7;
   // Reset values and masks
   localparam logic [7:0]  EPEVS_RST_STAT  = 8'h00;
   localparam logic [7:0]  EPEVS_RST_EN    = 8'h00;
   localparam logic [15:0] EPEVS_RST_ALARM = 16'h0000;
   localparam logic [7:0]  EPEVS_STAT_MASK = 8'h7f;
   localparam logic [7:0]  EPEVS_EN_MASK   = 8'hdf;
   // AXI responses
   localparam logic [1:0]  EPEVS_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  EPEVS_RESP_SLVERR = 2'b10;
endpackage

// ==== hw/epevs_ep_status.sv ====
// One endpoint's sticky transaction event flags
`timescale 1ns/1ps
module epevs_ep_status
   import epevs_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       out_short_packet_acked,
   input  wire logic       in_xfer_acked,
   input  wire logic       out_xfer_acked,
   input  wire logic       in_xfer_naked,
   input  wire logic       out_xfer_naked,
   input  wire logic       ping_naked,
   input  wire logic       in_stall,
   input  wire logic       in_pkt_error,
   input  wire logic       in_hs_timeout,
   input  wire logic       out_stall,
   input  wire logic       out_pkt_error,
   input  wire logic [7:0] clear_bits,
   output logic      [7:0] status_q
);
   logic [7:0] set_bits;

   always_comb
   begin
      set_bits                      = 8'h00;
      set_bits[EPEVS_BIT_OUT_SHORT] = out_short_packet_acked & out_xfer_acked;
      set_bits[EPEVS_BIT_IN_ACK]    = in_xfer_acked;
      set_bits[EPEVS_BIT_OUT_ACK]   = out_xfer_acked;
      set_bits[EPEVS_BIT_IN_NAK]    = in_xfer_naked;
      set_bits[EPEVS_BIT_OUT_NAK]   = out_xfer_naked | ping_naked;
      set_bits[EPEVS_BIT_IN_ERR]    = in_stall | in_pkt_error | in_hs_timeout;
      set_bits[EPEVS_BIT_OUT_ERR]   = out_stall | out_pkt_error;
   end

   // Set beats clear in the same cycle so no event is lost
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_q <= EPEVS_RST_STAT;
      else
         status_q <= ((status_q & ~clear_bits) | set_bits) & EPEVS_STAT_MASK;
   end
endmodule

// ==== hw/epevs_alarm.sv ====
// Alarm latches and response choice for IN tokens to unjoined endpoints
`timescale 1ns/1ps
module epevs_alarm
   import epevs_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        in_token_valid,
   input  wire logic [3:0]  in_token_ep,
   input  wire logic [15:0] in_endpoint_enable,
   input  wire logic [15:0] in_iso_response_select,
   input  wire logic [15:0] fifo_area_join,
   input  wire logic [15:0] clear_bits,
   output logic      [15:0] unjoined_in_alarm_q,
   output logic             send_zlp_q,
   output logic             send_nak_q
);
   logic [15:0] enabled;
   logic        hit;

   always_comb
   begin
      enabled    = in_endpoint_enable;
      enabled[0] = 1'b1;
      hit        = in_token_valid & enabled[in_token_ep] & ~fifo_area_join[in_token_ep];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         unjoined_in_alarm_q <= EPEVS_RST_ALARM;
      else
         unjoined_in_alarm_q <= (unjoined_in_alarm_q & ~clear_bits)
                                | ({15'h0000, hit} << in_token_ep);
   end

   // Response picked one cycle after the token, a single-cycle pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         send_zlp_q <= 1'b0;
         send_nak_q <= 1'b0;
      end
      else
      begin
         send_zlp_q <= hit & in_iso_response_select[in_token_ep];
         send_nak_q <= hit & ~in_iso_response_select[in_token_ep];
      end
   end
endmodule

// ==== hw/epevs_top.sv ====
// Endpoint event status block with AXI4-Lite register slave
`timescale 1ns/1ps
module epevs_top
   import epevs_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  out_short_packet_acked,
   input  wire logic [1:0]  in_xfer_acked,
   input  wire logic [1:0]  out_xfer_acked,
   input  wire logic [1:0]  in_xfer_naked,
   input  wire logic [1:0]  out_xfer_naked,
   input  wire logic [1:0]  ping_naked,
   input  wire logic [1:0]  in_stall,
   input  wire logic [1:0]  in_pkt_error,
   input  wire logic [1:0]  in_hs_timeout,
   input  wire logic [1:0]  out_stall,
   input  wire logic [1:0]  out_pkt_error,
   input  wire logic        in_token_valid,
   input  wire logic [3:0]  in_token_ep,
   input  wire logic [15:0] in_endpoint_enable,
   input  wire logic [15:0] in_iso_response_select,
   input  wire logic [15:0] fifo_area_join,
   output logic             send_zlp_q,
   output logic             send_nak_q,
   output logic             endpoint_group_summary_q
);
   // ------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------
   logic        aw_held_q;
   logic        w_held_q;
   logic [9:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        wstrb0_q;
   logic        do_write;
   logic [7:0]  clr_ep4;
   logic [7:0]  clr_ep5;
   logic [15:0] clr_alarm;
   logic [7:0]  ep4_stat;
   logic [7:0]  ep5_stat;
   logic [15:0] alarm_stat;
   logic [7:0]  group_enable_q;
   logic [7:0]  rd_byte;
   logic        rd_ok;
   logic        ep4_flagged;
   logic        ep5_flagged;
   logic        alarm_flagged;

   function automatic logic hit_addr(input logic [9:0] a, input logic [7:0] idx);
      hit_addr = (a[9:2] == idx);
   endfunction

   assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q     <= 1'b0;
         s_axi_awready <= 1'b0;
         awaddr_q      <= 10'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_q     <= 1'b1;
         s_axi_awready <= 1'b0;
         awaddr_q      <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held_q     <= 1'b0;
      else
         s_axi_awready <= ~aw_held_q & ~s_axi_bvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_q     <= 1'b0;
         s_axi_wready <= 1'b0;
         wdata_q      <= 32'h0000_0000;
         wstrb0_q     <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_q     <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_q      <= s_axi_wdata;
         wstrb0_q     <= s_axi_wstrb[0];
      end
      else if (do_write)
         w_held_q     <= 1'b0;
      else
         s_axi_wready <= ~w_held_q & ~s_axi_bvalid;
   end

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   // Registers are byte-wide; only lane 0 carries data, others ignored
   always_comb
   begin
      clr_ep4   = 8'h00;
      clr_ep5   = 8'h00;
      clr_alarm = 16'h0000;
      if (do_write && wstrb0_q)
      begin
         if (hit_addr(awaddr_q, EPEVS_OFF_EP4))
            clr_ep4 = wdata_q[7:0];
         else if (hit_addr(awaddr_q, EPEVS_OFF_EP5))
            clr_ep5 = wdata_q[7:0];
         else if (hit_addr(awaddr_q, EPEVS_OFF_ALARM_HI))
            clr_alarm[15:8] = wdata_q[7:0];
         else if (hit_addr(awaddr_q, EPEVS_OFF_ALARM_LO))
            clr_alarm[7:0] = wdata_q[7:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         group_enable_q <= EPEVS_RST_EN;
      else if (do_write && wstrb0_q && hit_addr(awaddr_q, EPEVS_OFF_GRP_EN))
         group_enable_q <= wdata_q[7:0] & EPEVS_EN_MASK;
   end

   function automatic logic mapped(input logic [9:0] a);
      mapped = hit_addr(a, EPEVS_OFF_EP4) || hit_addr(a, EPEVS_OFF_EP5)
               || hit_addr(a, EPEVS_OFF_ALARM_HI) || hit_addr(a, EPEVS_OFF_ALARM_LO)
               || hit_addr(a, EPEVS_OFF_GRP_EN) || hit_addr(a, EPEVS_OFF_SUMMARY);
   endfunction

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= EPEVS_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(awaddr_q) ? EPEVS_RESP_OKAY : EPEVS_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   // Each register owns one aligned word; the two low address bits are ignored
   always_comb
   begin
      rd_byte = 8'h00;
      rd_ok   = mapped(s_axi_araddr);
      if (hit_addr(s_axi_araddr, EPEVS_OFF_EP4))
         rd_byte = ep4_stat;
      else if (hit_addr(s_axi_araddr, EPEVS_OFF_EP5))
         rd_byte = ep5_stat;
      else if (hit_addr(s_axi_araddr, EPEVS_OFF_ALARM_HI))
         rd_byte = alarm_stat[15:8];
      else if (hit_addr(s_axi_araddr, EPEVS_OFF_ALARM_LO))
         rd_byte = alarm_stat[7:0];
      else if (hit_addr(s_axi_araddr, EPEVS_OFF_GRP_EN))
         rd_byte = group_enable_q;
      else if (hit_addr(s_axi_araddr, EPEVS_OFF_SUMMARY))
         rd_byte = {7'h00, endpoint_group_summary_q};
   end

   // ------------------------------------------------------------
   // Read handshake
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= EPEVS_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= rd_ok ? EPEVS_RESP_OKAY : EPEVS_RESP_SLVERR;
         s_axi_rdata   <= {24'h000000, rd_byte};
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid  <= 1'b0;
      else
         s_axi_arready <= ~s_axi_rvalid;
   end

   // ------------------------------------------------------------
   // Status latches
   // ------------------------------------------------------------
   epevs_ep_status u_ep4 (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .out_short_packet_acked (out_short_packet_acked[0]),
      .in_xfer_acked          (in_xfer_acked[0]),
      .out_xfer_acked         (out_xfer_acked[0]),
      .in_xfer_naked          (in_xfer_naked[0]),
      .out_xfer_naked         (out_xfer_naked[0]),
      .ping_naked             (ping_naked[0]),
      .in_stall               (in_stall[0]),
      .in_pkt_error           (in_pkt_error[0]),
      .in_hs_timeout          (in_hs_timeout[0]),
      .out_stall              (out_stall[0]),
      .out_pkt_error          (out_pkt_error[0]),
      .clear_bits             (clr_ep4),
      .status_q               (ep4_stat)
   );

   epevs_ep_status u_ep5 (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .out_short_packet_acked (out_short_packet_acked[1]),
      .in_xfer_acked          (in_xfer_acked[1]),
      .out_xfer_acked         (out_xfer_acked[1]),
      .in_xfer_naked          (in_xfer_naked[1]),
      .out_xfer_naked         (out_xfer_naked[1]),
      .ping_naked             (ping_naked[1]),
      .in_stall               (in_stall[1]),
      .in_pkt_error           (in_pkt_error[1]),
      .in_hs_timeout          (in_hs_timeout[1]),
      .out_stall              (out_stall[1]),
      .out_pkt_error          (out_pkt_error[1]),
      .clear_bits             (clr_ep5),
      .status_q               (ep5_stat)
   );

   // Software must join the endpoint afterwards or alarms keep coming
   epevs_alarm u_alarm (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .in_token_valid         (in_token_valid),
      .in_token_ep            (in_token_ep),
      .in_endpoint_enable     (in_endpoint_enable),
      .in_iso_response_select (in_iso_response_select),
      .fifo_area_join         (fifo_area_join),
      .clear_bits             (clr_alarm),
      .unjoined_in_alarm_q    (alarm_stat),
      .send_zlp_q             (send_zlp_q),
      .send_nak_q             (send_nak_q)
   );

   // ------------------------------------------------------------
   // Summary
   // ------------------------------------------------------------
   always_comb
   begin
      ep4_flagged   = group_enable_q[EPEVS_EN_EP4] & (|ep4_stat);
      ep5_flagged   = group_enable_q[EPEVS_EN_EP5] & (|ep5_stat);
      alarm_flagged = group_enable_q[EPEVS_EN_ALARM_IN] & (|alarm_stat);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         endpoint_group_summary_q <= 1'b0;
      else
         endpoint_group_summary_q <= ep4_flagged | ep5_flagged | alarm_flagged;
   end
endmodule

// ==== sim/epevs_props.sv ====
// Checker for the endpoint event status block
`timescale 1ns/1ps
module epevs_props
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        in_token_valid,
   input wire logic [3:0]  in_token_ep,
   input wire logic [15:0] in_endpoint_enable,
   input wire logic [15:0] in_iso_response_select,
   input wire logic [15:0] fifo_area_join,
   input wire logic        send_zlp_q,
   input wire logic        send_nak_q,
   input wire logic        endpoint_group_summary_q
);
   // ------------------------------
   // Alarm condition
   // ------------------------------
   wire logic alarm_c  = in_token_valid && !fifo_area_join[in_token_ep]
                         && (in_endpoint_enable[in_token_ep] || in_token_ep == 4'h0);
   wire logic any_resp = send_zlp_q || send_nak_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------
   // Properties
   // ------------------------------
   a_alarm_zlp: assert property (alarm_c && in_iso_response_select[in_token_ep]
      |=> send_zlp_q && !send_nak_q) else $error("zero-length answer missing");
   a_alarm_nak: assert property (alarm_c && !in_iso_response_select[in_token_ep]
      |=> send_nak_q && !send_zlp_q) else $error("NAK answer missing");
   a_ep0_enabled: assert property (in_token_valid && in_token_ep == 4'h0 && !fifo_area_join[0]
      |=> any_resp) else $error("endpoint zero not alarmed");
   a_joined_quiet: assert property (in_token_valid && fifo_area_join[in_token_ep]
      |=> !any_resp) else $error("joined endpoint alarmed");
   a_disabled_quiet: assert property (in_token_valid && in_token_ep != 4'h0
      && !in_endpoint_enable[in_token_ep] |=> !any_resp) else $error("disabled endpoint alarmed");
   a_resp_single: assert property (!(send_zlp_q && send_nak_q))
      else $error("both answers at once");
   a_resp_cause: assert property (any_resp |-> $past(in_token_valid))
      else $error("answer without token");
   a_sum_reset: assert property ($rose(aresetn) |-> !endpoint_group_summary_q)
      else $error("summary set after reset");
   // Flags only clear by a write, so a falling summary must follow a write response
   a_sum_sticky: assert property ($fell(endpoint_group_summary_q) && $past(aresetn)
      |-> $past(s_axi_bvalid)) else $error("summary fell without a write");
   c_zlp: cover property (send_zlp_q);
   c_nak: cover property (send_nak_q);
   c_sum: cover property ($rose(endpoint_group_summary_q));
endmodule
bind epevs_top epevs_props chk (.aclk, .aresetn, .s_axi_bvalid, .in_token_valid, .in_token_ep, .in_endpoint_enable,
   .in_iso_response_select, .fifo_area_join, .send_zlp_q, .send_nak_q, .endpoint_group_summary_q);

// ==== sim/epevs_usb_host.sv ====
// Host-side token source that records the device's answer
`timescale 1ns/1ps
module epevs_usb_host
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       go,
   input  wire logic [3:0] ep,
   input  wire logic       send_zlp_q,
   input  wire logic       send_nak_q,
   output logic            in_token_valid,
   output logic      [3:0] in_token_ep,
   output logic      [1:0] resp
);
   // ------------------------------
   // Token issue
   // ------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_token_valid <= 1'b0;
         in_token_ep    <= 4'h0;
      end
      else if (go && !in_token_valid)
      begin
         in_token_valid <= 1'b1;
         in_token_ep    <= ep;
      end
      else
      begin
         // Scrambled when idle, so a stale number is never trusted
         in_token_valid <= 1'b0;
         in_token_ep    <= ~in_token_ep;
      end
   end
   // ------------------------------
   // Answer capture
   // ------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn || (go && !in_token_valid))
         resp <= 2'b00;
      else if (send_zlp_q || send_nak_q)
         resp <= {send_zlp_q, send_nak_q};
   end
endmodule

// ==== sim/testbench.sv ====
// Self-checking testbench for the endpoint event status block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   import epevs_pkg::*;
   logic              aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go;
   logic [9:0]        s_axi_awaddr, s_axi_araddr;
   logic [7:0]        st, m, own, oth;
   logic [31:0]       s_axi_wdata, rd;
   logic [3:0]        s_axi_wstrb, tok_ep;
   logic [1:0]        ev [11];
   logic [1:0]        rs;
   logic [15:0]       in_endpoint_enable, in_iso_response_select, fifo_area_join, al, en_v, iso_v, jn_v;
   wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic         in_token_valid, send_zlp_q, send_nak_q, endpoint_group_summary_q;
   wire logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
   wire logic [31:0]  s_axi_rdata;
   wire logic [3:0]   in_token_ep;
   int                fail_count = 0, checks = 0, cyc = 0, e, i, j, p;
   logic              hit;
   epevs_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .out_short_packet_acked(ev[0]), .in_xfer_acked(ev[1]), .out_xfer_acked(ev[2]), .in_xfer_naked(ev[3]),
      .out_xfer_naked(ev[4]), .ping_naked(ev[5]), .in_stall(ev[6]), .in_pkt_error(ev[7]), .in_hs_timeout(ev[8]),
      .out_stall(ev[9]), .out_pkt_error(ev[10]), .in_token_valid, .in_token_ep, .in_endpoint_enable,
      .in_iso_response_select, .fifo_area_join, .send_zlp_q, .send_nak_q, .endpoint_group_summary_q);
   epevs_usb_host host (.aclk, .aresetn, .go, .ep(tok_ep), .send_zlp_q, .send_nak_q, .in_token_valid,
      .in_token_ep, .resp);
   // ------------------------------
   // Clock, timeout, verdict
   // ------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ------------------------------
   // Expectations and bus tasks
   // ------------------------------
   function automatic logic [7:0] ev_exp(input int k);
      case (k)
         0: return 8'h50;
         1: return 8'h20;
         2: return 8'h10;
         3: return 8'h08;
         4, 5: return 8'h04;
         6, 7, 8: return 8'h02;
         default: return 8'h01;
      endcase
   endfunction
   // The bus tasks axw and chkr take a register index; the byte address is four times it
   // A hit pulses the IN ACK event on the edge where the write lands
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic hit_c);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) aw_done = 1'b1;
         if (s_axi_wready) w_done = 1'b1;
         if (aw_done) s_axi_awvalid <= 1'b0;
         if (w_done) s_axi_wvalid <= 1'b0;
      end
      while (!(aw_done && w_done));
      ev[1] <= {1'b0, hit_c};
      @(posedge aclk);
      ev[1] <= 2'b00;
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic chkr(input logic [7:0] a, input logic [7:0] x);
      @(posedge aclk);
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      `CHK(rd, {24'h0, x})
   endtask
   task automatic fire(input int a, input int b, input logic [1:0] pm);
      @(posedge aclk);
      foreach (ev[q]) ev[q] <= (q == a || q == b || (q == 2 && a * b == 0)) ? pm : 2'b00;
      @(posedge aclk);
      foreach (ev[q]) ev[q] <= 2'b00;
   endtask
   // One IN token from the host model; its answer is captured two edges later
   task automatic token(input logic [3:0] t);
      tok_ep <= t;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tok_ep} = '0;
      {in_endpoint_enable, in_iso_response_select, fifo_area_join} = '0;
      s_axi_wstrb = 4'hf;
      foreach (ev[q]) ev[q] = 2'b00;
      void'($urandom(32'h797922f9));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (own[q]) chkr(8'hb9 + 8'(q), 8'h00);
      chkr(EPEVS_OFF_GRP_EN, 8'h00);
      `CHK(rs, EPEVS_RESP_OKAY)
      chkr(8'h00, 8'h00);
      `CHK(rs, EPEVS_RESP_SLVERR)
      axw(8'h04, 32'hff, 1'b0);
      `CHK(rs, EPEVS_RESP_SLVERR)
      $display("reset and map test done");
      for (int it = 0; it < 30; it++)
      begin
         e = $urandom % 2;
         i = (it < 11) ? it : $urandom % 11;
         j = (it < 11) ? it : $urandom % 11;
         own = e ? EPEVS_OFF_EP5 : EPEVS_OFF_EP4;
         oth = e ? EPEVS_OFF_EP4 : EPEVS_OFF_EP5;
         st = ev_exp(i) | ev_exp(j);
         fire(i, j, e ? 2'b10 : 2'b01);
         chkr(own, st);
         chkr(oth, 8'h00);
         m = 8'($urandom);
         axw(own, {24'h0, m}, 1'b0);
         chkr(own, st & ~m);
         axw(own, 32'hff, 1'b0);
         chkr(own, 8'h00);
      end
      $display("event flag test done");
      fire(1, 1, 2'b01);
      axw(EPEVS_OFF_EP4, 32'hff, 1'b1);
      chkr(EPEVS_OFF_EP4, 8'h20);
      axw(EPEVS_OFF_EP4, 32'h00, 1'b0);
      chkr(EPEVS_OFF_EP4, 8'h20);
      s_axi_wstrb <= 4'he;
      axw(EPEVS_OFF_EP4, 32'hff, 1'b0);
      s_axi_wstrb <= 4'hf;
      `CHK(rs, EPEVS_RESP_OKAY)
      chkr(EPEVS_OFF_EP4, 8'h20);
      `CHK(endpoint_group_summary_q, 1'b0)
      axw(EPEVS_OFF_GRP_EN, 32'h08, 1'b0);
      @(negedge aclk);
      `CHK(endpoint_group_summary_q, 1'b1)
      chkr(EPEVS_OFF_GRP_EN, 8'h08);
      axw(EPEVS_OFF_GRP_EN, 32'h10, 1'b0);
      @(negedge aclk);
      `CHK(endpoint_group_summary_q, 1'b0)
      $display("summary test done");
      al = 16'h0;
      for (int it = 0; it < 40; it++)
      begin
         p = (it < 16) ? it : $urandom % 16;
         en_v = (it == 0) ? 16'h0 : 16'($urandom);
         iso_v = 16'($urandom);
         jn_v = (it == 0) ? 16'h0 : 16'($urandom);
         in_endpoint_enable <= en_v;
         in_iso_response_select <= iso_v;
         fifo_area_join <= jn_v;
         token(4'(p));
         hit = (en_v[p] || p == 0) && !jn_v[p];
         `CHK(resp, hit ? (iso_v[p] ? 2'b10 : 2'b01) : 2'b00)
         if (hit) al[p] = 1'b1;
         chkr(EPEVS_OFF_ALARM_HI, al[15:8]);
         chkr(EPEVS_OFF_ALARM_LO, al[7:0]);
         m = 8'($urandom);
         axw(it[0] ? EPEVS_OFF_ALARM_HI : EPEVS_OFF_ALARM_LO, {24'h0, m}, 1'b0);
         if (it[0]) al[15:8] = al[15:8] & ~m;
         else al[7:0] = al[7:0] & ~m;
      end
      // Software reaction: join endpoint zero, after which its tokens go quiet
      axw(EPEVS_OFF_ALARM_LO, 32'h01, 1'b0);
      al[0] = 1'b0;
      fifo_area_join <= 16'h0001;
      token(4'h0);
      `CHK(resp, 2'b00)
      chkr(EPEVS_OFF_ALARM_LO, al[7:0]);
      axw(EPEVS_OFF_GRP_EN, 32'h80, 1'b0);
      @(negedge aclk);
      `CHK(endpoint_group_summary_q, |al)
      $display("alarm test done");
      complete_run();
   end
endmodule
